// ===== rtl/shfs_pkg.sv
`default_nettype none
package shfs_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFS_PRIORITY  = 4'h0;
  localparam logic [3:0] OFS_CONTROL   = 4'h4;
  localparam logic [3:0] OFS_FLAGS     = 4'h8;
  localparam logic [3:0] OFS_FAULT_ADR = 4'hC;

  // tick_and_pendable_priority fields
  localparam int TICK_PRIO_MSB    = 31;
  localparam int TICK_PRIO_LSB    = 28;
  localparam int PENDABLE_SERVICE_EXCEPTION_PRIO_MSB  = 23;
  localparam int PENDABLE_SERVICE_EXCEPTION_PRIO_LSB  = 20;
  localparam int PRIO_W           = 4;
  localparam logic [3:0] PRIO_RESET = 4'h0;

  // handler_control_and_state layout
  localparam int USAGE_ENA_BIT    = 18;
  localparam int BUS_ENA_BIT      = 17;
  localparam int MEM_ENA_BIT      = 16;
  localparam int SVC_PEND_BIT     = 15;
  localparam int BUS_PEND_BIT     = 14;
  localparam int MEM_PEND_BIT     = 13;
  localparam int USAGE_PEND_BIT   = 12;
  localparam int TICK_ACT_BIT     = 11;
  localparam int PENDABLE_SERVICE_EXCEPTION_ACT_BIT   = 10;
  localparam int MONITOR_ACT_BIT  = 8;
  localparam int SVC_ACT_BIT      = 7;
  localparam int USAGE_ACT_BIT    = 3;
  localparam int BUS_ACT_BIT      = 1;
  localparam int MEM_ACT_BIT      = 0;
  localparam logic [31:0] CONTROL_MASK  = 32'h0007_FD8B;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [11:0] ACTIVE_MASK   = 12'h0D8B;

  // memory_fault_status_byte positions in configurable_fault_flags
  localparam int FETCH_VIOL_BIT   = 0;
  localparam int DATA_VIOL_BIT    = 1;
  localparam int UNSTACK_ERR_BIT  = 3;
  localparam int STACK_ERR_BIT    = 4;
  localparam int LAZY_FP_ERR_BIT  = 5;
  localparam int ADR_VALID_BIT    = 7;
  localparam int NUM_FLAGS        = 6;
  localparam logic FLAG_RESET     = 1'b0;
  localparam logic [31:0] FAULT_ADR_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== rtl/shfs_sticky_flag.sv
`default_nettype none
module shfs_sticky_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // events
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q
);
  import shfs_pkg::*;

  logic next_q;

  // a raising event in the clearing cycle is kept
  assign next_q = set | (q & ~clr); // see RQ20

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= FLAG_RESET;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/shfs_system_handler.sv
// Function
// RQ1 - tick priority held in bits 31:24
// RQ2 - pendable service priority in bits 23:16
// RQ3 - priority low nibble reads zero, ignores writes
// RQ4 - enable bits for usage, bus, memory faults
// RQ5 - disabled fault handler escalates to hard fault
// RQ6 - pending bits read current pending state
// RQ7 - software writes set or clear pending
// RQ8 - active bits reflect exception active state
// RQ9 - software writes change active state
// RQ10 - software keeps stacked context consistent
// RQ11 - software uses read-modify-write after enabling
// RQ12 - fetch from non-executable location flags violation
// RQ13 - fetch violation captures no fault address
// RQ14 - load or store violation flags data violation
// RQ15 - data violation captures access address
// RQ16 - unstacking violation flag, no address capture
// RQ17 - stacking violation flag, no address capture
// RQ18 - address valid only when address captured
// RQ19 - lazy floating point violation flag
// RQ20 - flags stay until written one
// RQ21 - unused bits read zero, ignore writes
`default_nettype none
module shfs_system_handler #(
  parameter int ADR_W = 4
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // wishbone slave
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADR_W-1:0]  wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_wr,
  output logic      [31:0]       wb_dat_rd,
  output logic                   wb_ack,
  // core exception state events, bit positions as in the control register
  input  wire logic [3:0]        pend_set,
  input  wire logic [3:0]        pend_clr,
  input  wire logic [11:0]       active_set,
  input  wire logic [11:0]       active_clr,
  // fault requests {usage, bus, memory}
  input  wire logic [2:0]        fault_req,
  // memory protection events
  input  wire logic              fetch_access_violation_evt,
  input  wire logic              data_access_violation_evt,
  input  wire logic [31:0]       data_access_address,
  input  wire logic              unstacking_error_evt,
  input  wire logic              stacking_error_evt,
  input  wire logic              lazy_fp_error_evt,
  // exception state toward the core
  output logic      [shfs_pkg::PRIO_W-1:0] tick_priority_field,
  output logic      [shfs_pkg::PRIO_W-1:0] pendable_service_priority_field,
  output logic      [2:0]        fault_enable,
  output logic      [3:0]        exception_pending,
  output logic      [11:0]       exception_active,
  output logic      [2:0]        fault_take,
  output logic                   escalate_hard_fault
);
  import shfs_pkg::*;

  logic [PRIO_W-1:0] tick_prio;
  logic [PRIO_W-1:0] pendable_service_exception_prio;
  logic [31:0]       control;
  logic [31:0]       fault_adr;
  logic [NUM_FLAGS-1:0] flag_q;

  // bus decode
  wire        req_live     = wb_cyc & wb_stb;
  wire        write_fire   = req_live & wb_we & wb_ack;
  wire        hit_prio     = (wb_adr == ADR_W'(OFS_PRIORITY));
  wire        hit_ctl      = (wb_adr == ADR_W'(OFS_CONTROL));
  wire        hit_flags    = (wb_adr == ADR_W'(OFS_FLAGS));
  wire        hit_adr      = (wb_adr == ADR_W'(OFS_FAULT_ADR));
  wire [31:0] byte_mask    = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire        wr_prio      = write_fire & hit_prio;
  wire        wr_ctl       = write_fire & hit_ctl;
  wire        wr_flags     = write_fire & hit_flags;
  wire        wr_adr       = write_fire & hit_adr;

  // read values
  wire [31:0] prio_view    = {tick_prio, 4'h0, pendable_service_exception_prio, 4'h0, 16'h0000}; // see RQ3
  wire [31:0] flags_view   = {24'h00_0000, flag_q[5], 1'b0, flag_q[4:2], 1'b0,
                              flag_q[1:0]};
  logic [31:0] read_mux;
  always_comb begin
    if (hit_prio) begin
      read_mux = prio_view;
    end else if (hit_ctl) begin
      read_mux = control;
    end else if (hit_flags) begin
      read_mux = flags_view;
    end else if (hit_adr) begin
      read_mux = fault_adr;
    end else begin
      read_mux = 32'h0000_0000;
    end
  end

  // bus: one cycle to ack, data registered with it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack    <= 1'b0;
      wb_dat_rd <= 32'h0000_0000;
    end else begin
      wb_ack    <= req_live & ~wb_ack;
      wb_dat_rd <= (req_live & ~wb_ack & ~wb_we) ? read_mux : 32'h0000_0000;
    end
  end

  // priority register, upper nibble of bytes 3 and 2 only
  wire [PRIO_W-1:0] next_tick_prio =
    (wr_prio & wb_sel[3]) ? wb_dat_wr[TICK_PRIO_MSB:TICK_PRIO_LSB] : tick_prio; // see RQ1
  wire [PRIO_W-1:0] next_pendable_service_exception_prio =
    (wr_prio & wb_sel[2]) ? wb_dat_wr[PENDABLE_SERVICE_EXCEPTION_PRIO_MSB:PENDABLE_SERVICE_EXCEPTION_PRIO_LSB] : pendable_service_exception_prio; // see RQ2

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_prio   <= PRIO_RESET;
      pendable_service_exception_prio <= PRIO_RESET;
    end else begin
      tick_prio   <= next_tick_prio;
      pendable_service_exception_prio <= next_pendable_service_exception_prio;
    end
  end

  // control and state: enabled faults become pending, disabled ones escalate
  wire [2:0]  fault_enabled = {control[USAGE_ENA_BIT], control[BUS_ENA_BIT],
                               control[MEM_ENA_BIT]}; // see RQ4
  wire [2:0]  taken         = fault_req & fault_enabled;
  wire        escalate      = |(fault_req & ~fault_enabled); // see RQ5
  wire [3:0]  pend_set_all  = pend_set | {1'b0, taken[1], taken[0], taken[2]};
  wire [31:0] hw_set        = {16'h0000, pend_set_all, active_set & ACTIVE_MASK};
  wire [31:0] hw_clr        = {16'h0000, pend_clr, active_clr & ACTIVE_MASK};
  wire [31:0] sw_merged     = (control & ~byte_mask) | (wb_dat_wr & byte_mask);
  // software value stands in for the old state; hardware sets still win
  wire [31:0] next_control  =
    ((wr_ctl ? sw_merged : (control & ~hw_clr)) | hw_set) & CONTROL_MASK; // see RQ7, RQ9, RQ21

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
    end else begin
      control <= next_control; // see RQ6, RQ8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_take          <= 3'b000;
      escalate_hard_fault <= 1'b0;
    end else begin
      fault_take          <= taken;
      escalate_hard_fault <= escalate; // see RQ5
    end
  end

  // memory fault status flags, write one to clear
  wire [NUM_FLAGS-1:0] flag_set = {data_access_violation_evt, // see RQ18
                                   lazy_fp_error_evt,          // see RQ19
                                   stacking_error_evt,         // see RQ17
                                   unstacking_error_evt,       // see RQ16
                                   data_access_violation_evt,  // see RQ14
                                   fetch_access_violation_evt}; // see RQ12
  wire [31:0] w1c = (wr_flags ? (wb_dat_wr & byte_mask) : 32'h0000_0000);
  wire [NUM_FLAGS-1:0] flag_clr = {w1c[ADR_VALID_BIT], w1c[LAZY_FP_ERR_BIT],
                                   w1c[STACK_ERR_BIT], w1c[UNSTACK_ERR_BIT],
                                   w1c[DATA_VIOL_BIT], w1c[FETCH_VIOL_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      shfs_sticky_flag u_flag (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (flag_set[gi]),
        .clr   (flag_clr[gi]),
        .q     (flag_q[gi])
      );
    end
  endgenerate

  // a data violation, else a bus write, loads the address; other faults leave it alone
  wire [31:0] sw_adr        = (fault_adr & ~byte_mask) | (wb_dat_wr & byte_mask);
  wire [31:0] next_fault_adr = data_access_violation_evt ? data_access_address // see RQ15
                             : (wr_adr ? sw_adr : fault_adr); // see RQ13

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_adr <= FAULT_ADR_RESET;
    end else begin
      fault_adr <= next_fault_adr;
    end
  end

  // outputs toward the core
  assign tick_priority_field             = tick_prio;
  assign pendable_service_priority_field = pendable_service_exception_prio;
  assign fault_enable      = fault_enabled;
  assign exception_pending = control[SVC_PEND_BIT:USAGE_PEND_BIT];
  assign exception_active  = control[11:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tick_prio_write: assert property ( // see RQ1
    wr_prio && wb_sel[3] |=> tick_priority_field == $past(wb_dat_wr[31:28]))
    else $error("tick priority not stored");

  chk_pendable_service_exception_prio_write: assert property ( // see RQ2
    wr_prio && wb_sel[2] |=> pendable_service_priority_field == $past(wb_dat_wr[23:20]))
    else $error("pendable service priority not stored");

  chk_prio_low_zero: assert property ( // see RQ3
    req_live && !wb_ack && !wb_we && hit_prio |=> wb_ack && wb_dat_rd[27:24] == 4'h0
      && wb_dat_rd[19:16] == 4'h0 && wb_dat_rd[15:0] == 16'h0000)
    else $error("priority low bits not zero");

  chk_disabled_escalates: assert property ( // see RQ5
    fault_req[0] && !fault_enable[0] |=> escalate_hard_fault && !fault_take[0])
    else $error("disabled memory fault not escalated");

  chk_enabled_pends: assert property ( // see RQ4
    fault_req[0] && fault_enable[0] |=> fault_take[0] && exception_pending[1])
    else $error("enabled memory fault not pending");

  chk_pend_hw_set: assert property ( // see RQ6
    pend_set[3] |=> exception_pending[3])
    else $error("service call pending lost");

  chk_pend_sw_write: assert property ( // see RQ7
    wr_ctl && wb_sel[1] && pend_set_all == 4'h0 |=> exception_pending == $past(wb_dat_wr[15:12]))
    else $error("pending write not applied");

  chk_active_sw_write: assert property ( // see RQ9
    wr_ctl && wb_sel[0] && wb_sel[1] && active_set == 12'h000
      |=> exception_active == ($past(wb_dat_wr[11:0]) & ACTIVE_MASK))
    else $error("active write not applied");

  chk_data_adr_capture: assert property ( // see RQ15
    data_access_violation_evt |=> fault_adr == $past(data_access_address) && flag_q[5] && flag_q[1])
    else $error("data violation address not captured");

  chk_fetch_no_capture: assert property ( // see RQ13
    fetch_access_violation_evt && !data_access_violation_evt && !wr_adr |=> $stable(fault_adr))
    else $error("fetch violation changed address");

  chk_flag_sticky: assert property ( // see RQ20
    flag_q[4] && !flag_clr[4] |=> flag_q[4])
    else $error("lazy fp flag dropped");

  chk_enable_write: assert property ( // see RQ4
    wr_ctl && wb_sel[2] |=> fault_enable == $past(wb_dat_wr[18:16]))
    else $error("fault enable write not applied");

  chk_pend_hw_clr: assert property ( // see RQ6
    pend_clr[3] && !pend_set[3] && !wr_ctl |=> !exception_pending[3])
    else $error("service call pending not cleared");

  chk_active_hw_set: assert property ( // see RQ8
    active_set[11] |=> exception_active[11])
    else $error("tick active not set");

  chk_fetch_flag_set: assert property ( // see RQ12
    fetch_access_violation_evt |=> flag_q[0])
    else $error("fetch violation flag not set");

  chk_data_flag_set: assert property ( // see RQ14
    data_access_violation_evt |=> flag_q[1])
    else $error("data violation flag not set");

  chk_unstack_no_capture: assert property ( // see RQ16
    unstacking_error_evt && !data_access_violation_evt && !wr_adr
      |=> flag_q[2] && $stable(fault_adr))
    else $error("unstacking flag or address wrong");

  chk_stack_no_capture: assert property ( // see RQ17
    stacking_error_evt && !data_access_violation_evt && !wr_adr
      |=> flag_q[3] && $stable(fault_adr))
    else $error("stacking flag or address wrong");

  chk_lazy_flag_set: assert property ( // see RQ19
    lazy_fp_error_evt |=> flag_q[4])
    else $error("lazy fp flag not set");

  chk_adr_valid_clear: assert property ( // see RQ18
    wr_flags && w1c[ADR_VALID_BIT] && !data_access_violation_evt |=> !flag_q[5])
    else $error("address valid flag not cleared");

  chk_flag_w1c: assert property ( // see RQ20
    wr_flags && w1c[FETCH_VIOL_BIT] && !fetch_access_violation_evt |=> !flag_q[0])
    else $error("fetch flag not cleared by write one");

  chk_flags_unused_zero: assert property ( // see RQ21
    req_live && !wb_ack && !wb_we && hit_flags
      |=> wb_dat_rd[31:8] == 24'h00_0000 && !wb_dat_rd[6] && !wb_dat_rd[2])
    else $error("unused flag bits not zero");

  chk_bus_ack: assert property (
    req_live && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("ack not one cycle after request");
endmodule
`default_nettype wire

// ===== test/shfs_system_handler_tb.sv
`default_nettype none
module shfs_system_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import shfs_pkg::*;
  typedef struct packed {logic [4:0] adr; logic [31:0] wr; logic [31:0] exp;} shfs_row_t;
  // write then read back; 5'h10 lies past the last register
  localparam shfs_row_t ROWS [7] = '{
    '{5'h00, 32'hFFFF_FFFF, 32'hF0F0_0000}, '{5'h00, 32'h5A3C_1234, 32'h5030_0000},
    '{5'h04, 32'hFFFF_FFFF, 32'h0007_FD8B}, '{5'h04, 32'h0000_0000, 32'h0000_0000},
    '{5'h08, 32'hFFFF_FFFF, 32'h0000_0000}, '{5'h0C, 32'h1234_5678, 32'h1234_5678},
    '{5'h10, 32'hFFFF_FFFF, 32'h0000_0000}};
  logic        clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, escalate_hard_fault;
  logic        fetch_evt, data_evt, unstack_evt, stack_evt, lazy_evt;
  logic [4:0]  wb_adr;
  logic [3:0]  wb_sel, pend_set, pend_clr, exception_pending, tick_prio, pend_prio;
  logic [31:0] wb_dat_wr, wb_dat_rd, data_access_address, rd;
  logic [11:0] active_set, active_clr, exception_active;
  logic [2:0]  fault_req, fault_enable, fault_take;
  int          n_fail, checked;

  shfs_system_handler #(.ADR_W(5)) uut (
    .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
    .wb_ack(wb_ack), .pend_set(pend_set), .pend_clr(pend_clr), .active_set(active_set),
    .active_clr(active_clr), .fault_req(fault_req), .fetch_access_violation_evt(fetch_evt),
    .data_access_violation_evt(data_evt), .data_access_address(data_access_address),
    .unstacking_error_evt(unstack_evt), .stacking_error_evt(stack_evt),
    .lazy_fp_error_evt(lazy_evt), .tick_priority_field(tick_prio),
    .pendable_service_priority_field(pend_prio), .fault_enable(fault_enable),
    .exception_pending(exception_pending), .exception_active(exception_active),
    .fault_take(fault_take), .escalate_hard_fault(escalate_hard_fault));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; rd holds what came with ack
  task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [3:0] sel,
                         input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc    <= 1'b1;
    wb_stb    <= 1'b1;
    wb_we     <= we;
    wb_adr    <= adr;
    wb_sel    <= sel;
    wb_dat_wr <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1);
    check("ack latency", n, 2);
    rd = wb_dat_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 4'hF, 32'h0);
    check("read", rd, exp);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    finish_test;
  end

  initial begin
    {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_wr} = '0;
    {pend_set, pend_clr, active_set, active_clr, fault_req} = '0;
    {fetch_evt, data_evt, unstack_evt, stack_evt, lazy_evt, data_access_address} = '0;
    repeat (8) @(posedge clk);
    check("reset outs", {wb_ack, escalate_hard_fault, fault_take, exception_active}, 0);
    rst_n <= 1'b1;
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h04, CONTROL_RESET);
    rd_chk(5'h08, 32'h0);
    foreach (ROWS[i]) begin
      wb_xfer(1'b1, ROWS[i].adr, 4'hF, ROWS[i].wr);
      rd_chk(ROWS[i].adr, ROWS[i].exp);
    end
    check("prio out", {tick_prio, pend_prio}, 8'h53);
    // a lone byte lane only touches its own field
    wb_xfer(1'b1, 5'h00, 4'b0100, 32'hFFFF_FFFF);
    rd_chk(5'h00, 32'h50F0_0000);
    // each fault, first disabled then enabled
    for (int i = 0; i < 3; i++) begin
      foreach (ROWS[j]) if (j < 2) begin
        wb_xfer(1'b1, 5'h04, 4'hF, j ? 32'h1 << (16 + i) : 32'h0);
        fault_req <= 3'b001 << i;
        @(posedge clk);
        fault_req <= 3'b000;
        #1 check("escalate", escalate_hard_fault, !j);
        check("take", fault_take, j ? 3'b001 << i : 3'b000);
        check("enable out", fault_enable, j ? 3'b001 << i : 3'b000);
      end
    end
    wb_xfer(1'b1, 5'h04, 4'hF, 32'h0);
    pend_set   <= 4'hF;
    active_set <= 12'hFFF;
    @(posedge clk);
    pend_set   <= 4'h0;
    active_set <= 12'h0;
    rd_chk(5'h04, 32'h0000_FD8B);
    check("active out", exception_active, ACTIVE_MASK);
    pend_clr   <= 4'b1010;
    active_clr <= 12'h0FF;
    @(posedge clk);
    pend_clr   <= 4'h0;
    active_clr <= 12'h0;
    rd_chk(5'h04, 32'h0000_5D00);
    // software rewrites pending and active directly
    wb_xfer(1'b1, 5'h04, 4'hF, 32'h0000_A08A);
    rd_chk(5'h04, 32'h0000_A08A);
    check("pend out", exception_pending, 4'b1010);
    check("active out", exception_active, 12'h08A);
    // read-modify-write of one enable bit keeps the rest
    wb_xfer(1'b1, 5'h04, 4'hF, rd | 32'h0002_0000);
    rd_chk(5'h04, 32'h0002_A08A);
    // kernel switches the active state, then restores what it saved
    wb_xfer(1'b1, 5'h04, 4'hF, (rd & ~32'h0000_0FFF) | 32'h0000_0400);
    rd_chk(5'h04, 32'h0002_A400);
    wb_xfer(1'b1, 5'h04, 4'hF, 32'h0002_A08A);
    rd_chk(5'h04, 32'h0002_A08A);
    data_access_address <= 32'hCAFE_0010;
    {fetch_evt, data_evt, unstack_evt, stack_evt, lazy_evt} <= 5'b11111;
    @(posedge clk);
    {fetch_evt, data_evt, unstack_evt, stack_evt, lazy_evt} <= 5'b00000;
    data_access_address <= 32'h0;
    repeat (4) @(posedge clk);
    rd_chk(5'h08, 32'h0000_00BB);
    rd_chk(5'h0C, 32'hCAFE_0010);
    wb_xfer(1'b1, 5'h08, 4'hF, 32'h0000_0001);
    rd_chk(5'h08, 32'h0000_00BA);
    wb_xfer(1'b1, 5'h08, 4'hF, 32'h0000_0080);
    rd_chk(5'h08, 32'h0000_003A);
    wb_xfer(1'b1, 5'h08, 4'hF, 32'hFFFF_FFFF);
    rd_chk(5'h08, 32'h0);
    // fetch violation leaves the address alone
    fetch_evt <= 1'b1;
    data_access_address <= 32'h5555_AAAA;
    @(posedge clk);
    fetch_evt <= 1'b0;
    rd_chk(5'h08, 32'h0000_0001);
    rd_chk(5'h0C, 32'hCAFE_0010);
    // unstack, stack and lazy flags one by one
    for (int k = 0; k < 3; k++) begin
      {unstack_evt, stack_evt, lazy_evt} <= 3'b100 >> k;
      @(posedge clk);
      {unstack_evt, stack_evt, lazy_evt} <= 3'b000;
      // flags stay set, so each pass adds one more bit
      rd_chk(5'h08, 32'h1 | ((32'h10 << k) - 32'h8));
    end
    // reset in mid-run returns the priority, control and flag registers to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset mid", {tick_prio, pend_prio, exception_pending, fault_enable}, 0);
    rst_n <= 1'b1;
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h04, CONTROL_RESET);
    rd_chk(5'h08, 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
